// [common/enc_i2c_pkg.sv]
// Constants shared by both ends of the encoder control port.
// Assumes a 40 MHz core clock on both ends.
package enc_i2c_pkg;
	// Bus address without the direction bit
	localparam logic [6:0] DEV_ADDR = 7'h44;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [7:0] QUARTER_CNT = 8'(QUARTER_CYC - 1);

	localparam logic [7:0] SUB_DAC_FINE = 8'h16;
	localparam logic [7:0] SUB_RED_COARSE = 8'h17;
	localparam logic [7:0] SUB_GREEN_COARSE = 8'h18;
	localparam logic [7:0] SUB_BLUE_COARSE = 8'h19;
	localparam logic [7:0] SUB_THRESHOLD = 8'h1a;
	localparam logic [7:0] SUB_SENSE = 8'h1b;
	localparam logic [7:0] SUB_WSS_LOW = 8'h26;
	localparam logic [7:0] SUB_WSS_HIGH = 8'h27;
	localparam logic [7:0] SUB_BURST = 8'h28;
	localparam logic [7:0] SUB_LINE_COUNT = 8'hd0;
	localparam logic [7:0] SUB_CURSOR = 8'hfe;
	localparam logic [7:0] SUB_CLUT = 8'hff;

	localparam logic [3:0] RST_DAC_FINE = 4'h0;
	localparam logic [4:0] RST_RED_COARSE = 5'h1b;
	localparam logic [4:0] RST_GREEN_COARSE = 5'h1b;
	localparam logic [4:0] RST_BLUE_COARSE = 5'h1f;
	localparam logic [7:0] RST_THRESHOLD = 8'h00;
	localparam logic RST_SENSE_ENABLE = 1'b0;
	localparam logic RST_AUTO_SENSE = 1'b0;
	localparam logic RST_DETECT_TRISTATE = 1'b1;
	localparam logic [13:0] RST_WSS = 14'h0000;
	localparam logic RST_WSS_ENABLE = 1'b0;
	localparam logic [7:0] RST_BURST_PAL = 8'h21;
	localparam logic [7:0] RST_BURST_NTSC = 8'h19;

	// Field positions in the sense byte and wide-screen high byte, and the index of the last colour table component
	localparam int SENSE_ENABLE_BIT = 7;
	localparam int AUTO_SENSE_BIT = 6;
	localparam int DETECT_TRISTATE_BIT = 5;
	localparam int WSS_ENABLE_BIT = 7;
	localparam logic [1:0] CLUT_LAST_COMPONENT = 2'h2;
endpackage

// [common/i2c_link_if.sv]
// Two-wire control link between host master and encoder slave.
// Assumes pull-ups: a released line reads high, any driver pulls it low.
`timescale 1ns/10ps
interface i2c_link_if;
	logic master_scl_out;
	logic master_scl_oe_n;
	logic master_sda_out;
	logic master_sda_oe_n;
	logic slave_sda_out;
	logic slave_sda_oe_n;
	logic scl;
	logic sda;

	// Wired-AND of open-drain drivers
	assign scl = master_scl_oe_n | master_scl_out;
	assign sda = (master_sda_oe_n | master_sda_out) & (slave_sda_oe_n | slave_sda_out);

	modport slave(input scl, input sda, output slave_sda_out, output slave_sda_oe_n);
	modport master(input scl, input sda, output master_scl_out, output master_scl_oe_n,
		output master_sda_out, output master_sda_oe_n);
endinterface

// [rtl/video_encoder_i2c_port.sv]
// Encoder end of the control link: serial slave, control registers and the
// line-count, cursor and colour table arrays. Assumes scl/sda and comparator
// inputs are asynchronous to core_clk_in; scl is made by the host.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Write: address, subaddress, data, each acknowledged
// R2 - Read: subaddress write, restart, read address, data
// R3 - Seven-bit address, direction bit selects read/write
// R4 - Subaddress increments after every register data byte; not after a read byte the master does not acknowledge
// R5 - Line-count array: RAM address then data
// R6 - Cursor map: RAM address then sequential data
// R7 - Colour table: RAM address then RGB triplets
// R8 - Array reads: subaddress, RAM address, restart, read
// R9 - Fine gain is four-bit sign-magnitude code
// R10 - Coarse levels reset to 1b, 1b, 1f
// R11 - Host programs sense threshold to 70
// R12 - Sense disabled means comparator bits invalid
// R13 - Auto sense only while manual sense off
// R14 - Detect pin tristate bit, reset one
// R15 - Comparator bits read-only, one means unloaded
// R16 - Wide-screen value: 14 bits over two bytes
// R17 - Wide-screen output enable, reset zero
// R18 - Burst start reset from strap pin
// R19 - Host writes zero to unused bits
// R20 - Writes to comparator bits are ignored
module video_encoder_i2c_port import enc_i2c_pkg::*; (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	i2c_link_if.slave link,
	input wire logic standard_strap_pin_in,
	input wire logic red_load_status_in,
	input wire logic green_load_status_in,
	input wire logic blue_load_status_in,
	output logic [3:0] dac_gain_fine_out,
	output logic [4:0] red_level_coarse_out,
	output logic [4:0] green_level_coarse_out,
	output logic [4:0] blue_level_coarse_out,
	output logic [7:0] sense_threshold_out,
	output logic monitor_sense_enable_out,
	output logic auto_sense_enable_out,
	output logic auto_sense_active_out,
	output logic tv_detect_pin_out,
	output logic tv_detect_pin_oe_n_out,
	output logic [13:0] wide_screen_bits_out,
	output logic wide_screen_output_enable_out,
	output logic [7:0] burst_start_out
);
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_recv = 3'b001,
		st_ackwait = 3'b010,
		st_ack = 3'b011,
		st_send = 3'b100,
		st_mack = 3'b101,
		st_mack_fall = 3'b110
	} slave_state_type;

	slave_state_type state;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_prev;
	logic sda_prev;
	logic [2:0] comp_meta;
	logic [2:0] comp_sync;
	logic strap_meta;
	logic strap_sync;
	logic [2:0] bit_cnt;
	logic [1:0] byte_idx;
	logic [7:0] shift;
	logic [7:0] tx;
	logic read_mode;
	logic ack_ok;
	logic sda_oe_n;
	logic [7:0] subaddr;
	logic [7:0] ram_ptr;
	logic [1:0] comp;
	logic detect_pin_tristate;
	logic [7:0] line_ram [256];
	logic [7:0] cursor_ram [256];
	logic [7:0] clut_red [256];
	logic [7:0] clut_green [256];
	logic [7:0] clut_blue [256];
	logic [7:0] rd_byte;
	logic [7:0] rx_byte;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_end;
	logic data_wr;
	logic adv;
	logic ram_mode;
	logic sense_valid;
	logic [2:0] load_status;

	function automatic logic is_ram(input logic [7:0] sub);
		is_ram = (sub == SUB_LINE_COUNT) || (sub == SUB_CURSOR) || (sub == SUB_CLUT);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Synchronisers
	always_ff @(posedge core_clk_in) begin
		scl_sync <= {scl_sync[0], link.scl};
		sda_sync <= {sda_sync[0], link.sda};
		scl_prev <= scl_sync[1];
		sda_prev <= sda_sync[1];
		comp_meta <= {red_load_status_in, green_load_status_in, blue_load_status_in};
		comp_sync <= comp_meta;
		strap_meta <= standard_strap_pin_in;
		strap_sync <= strap_meta;
	end

	assign scl_rise = scl_sync[1] & ~scl_prev;
	assign scl_fall = ~scl_sync[1] & scl_prev;
	assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
	assign stop_cond = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
	assign rx_byte = {shift[6:0], sda_sync[1]};
	assign byte_end = scl_rise && (state == st_recv) && (bit_cnt == 3'h7);
	assign data_wr = byte_end && (byte_idx == 2'h3); // see R1
	assign adv = data_wr || (scl_rise && (state == st_mack) && !sda_sync[1]);
	assign ram_mode = is_ram(subaddr);
	assign sense_valid = monitor_sense_enable_out | auto_sense_active_out;
	// Invalid comparator results read as unloaded
	assign load_status = sense_valid ? comp_sync : 3'h7; // see R12
	assign link.slave_sda_out = 1'b0;
	assign link.slave_sda_oe_n = sda_oe_n;

	//////////////////////////////////////////////////////////////////////////
	// Serial protocol
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			state <= st_idle;
			bit_cnt <= 3'h0;
			byte_idx <= 2'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			read_mode <= 1'b0;
			ack_ok <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (stop_cond) begin
			state <= st_idle;
			sda_oe_n <= 1'b1;
		end else if (start_cond) begin
			// Repeated start keeps the pointers for the read phase
			state <= st_recv; // see R2
			bit_cnt <= 3'h0;
			byte_idx <= 2'h0;
			sda_oe_n <= 1'b1;
		end else begin
			case (state)
				st_recv: begin
					if (scl_rise) begin
						shift <= rx_byte;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							state <= st_ackwait;
							ack_ok <= (byte_idx != 2'h0) || (rx_byte[7:1] == DEV_ADDR); // see R3
							if (byte_idx == 2'h0) begin
								read_mode <= rx_byte[0]; // see R3
								byte_idx <= 2'h1;
							end else if (byte_idx == 2'h1) begin
								byte_idx <= is_ram(rx_byte) ? 2'h2 : 2'h3; // see R5, R6, R7
							end else begin
								byte_idx <= 2'h3;
							end
						end
					end
				end
				st_ackwait: begin
					if (scl_fall) begin
						sda_oe_n <= !ack_ok; // see R1
						state <= ack_ok ? st_ack : st_idle;
					end
				end
				st_ack: begin
					if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (read_mode) begin
							tx <= {rd_byte[6:0], 1'b0};
							sda_oe_n <= rd_byte[7]; // see R2
							state <= st_send;
						end else begin
							sda_oe_n <= 1'b1;
							state <= st_recv;
						end
					end
				end
				st_send: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h7) begin
							sda_oe_n <= 1'b1;
							state <= st_mack;
						end else begin
							sda_oe_n <= tx[7];
							tx <= {tx[6:0], 1'b0};
							bit_cnt <= bit_cnt + 3'h1;
						end
					end
				end
				st_mack: begin
					// Master not-acknowledge ends the read
					if (scl_rise) begin
						state <= sda_sync[1] ? st_idle : st_mack_fall; // see R2
					end
				end
				st_mack_fall: begin
					if (scl_fall) begin
						bit_cnt <= 3'h0;
						tx <= {rd_byte[6:0], 1'b0};
						sda_oe_n <= rd_byte[7]; // see R8
						state <= st_send;
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Subaddress and RAM pointers
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			subaddr <= 8'h00;
			ram_ptr <= 8'h00;
			comp <= 2'h0;
		end else if (byte_end && (byte_idx == 2'h1)) begin
			subaddr <= rx_byte;
			comp <= 2'h0;
		end else if (byte_end && (byte_idx == 2'h2)) begin
			ram_ptr <= rx_byte; // see R5, R6, R8
			comp <= 2'h0;
		end else if (adv) begin
			if (ram_mode) begin
				if ((subaddr == SUB_CLUT) && (comp != CLUT_LAST_COMPONENT)) begin
					comp <= comp + 2'h1; // see R7
				end else begin
					comp <= 2'h0;
					ram_ptr <= ram_ptr + 8'h01; // see R5, R6
				end
			end else begin
				subaddr <= subaddr + 8'h01; // see R4
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			dac_gain_fine_out <= RST_DAC_FINE;
			red_level_coarse_out <= RST_RED_COARSE; // see R10
			green_level_coarse_out <= RST_GREEN_COARSE;
			blue_level_coarse_out <= RST_BLUE_COARSE;
			sense_threshold_out <= RST_THRESHOLD;
			monitor_sense_enable_out <= RST_SENSE_ENABLE;
			auto_sense_enable_out <= RST_AUTO_SENSE;
			detect_pin_tristate <= RST_DETECT_TRISTATE; // see R14
			wide_screen_bits_out <= RST_WSS;
			wide_screen_output_enable_out <= RST_WSS_ENABLE; // see R17
			burst_start_out <= strap_sync ? RST_BURST_PAL : RST_BURST_NTSC; // see R18
		end else if (data_wr && !ram_mode) begin
			if (subaddr == SUB_DAC_FINE) begin
				dac_gain_fine_out <= rx_byte[3:0]; // see R9
			end else if (subaddr == SUB_RED_COARSE) begin
				red_level_coarse_out <= rx_byte[4:0];
			end else if (subaddr == SUB_GREEN_COARSE) begin
				green_level_coarse_out <= rx_byte[4:0];
			end else if (subaddr == SUB_BLUE_COARSE) begin
				blue_level_coarse_out <= rx_byte[4:0];
			end else if (subaddr == SUB_THRESHOLD) begin
				sense_threshold_out <= rx_byte;
			end else if (subaddr == SUB_SENSE) begin
				// Comparator bits are not stored
				monitor_sense_enable_out <= rx_byte[SENSE_ENABLE_BIT]; // see R12, R20
				auto_sense_enable_out <= rx_byte[AUTO_SENSE_BIT];
				detect_pin_tristate <= rx_byte[DETECT_TRISTATE_BIT]; // see R14
			end else if (subaddr == SUB_WSS_LOW) begin
				wide_screen_bits_out[7:0] <= rx_byte; // see R16
			end else if (subaddr == SUB_WSS_HIGH) begin
				wide_screen_bits_out[13:8] <= rx_byte[5:0]; // see R16
				wide_screen_output_enable_out <= rx_byte[WSS_ENABLE_BIT]; // see R17
			end else if (subaddr == SUB_BURST) begin
				burst_start_out <= rx_byte; // see R18
			end
		end
	end

	// Derived sense outputs, registered so every port comes from a flop
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			auto_sense_active_out <= 1'b0;
			tv_detect_pin_out <= 1'b0;
			tv_detect_pin_oe_n_out <= 1'b1;
		end else begin
			auto_sense_active_out <= auto_sense_enable_out & ~monitor_sense_enable_out; // see R13
			tv_detect_pin_out <= sense_valid & ~(&comp_sync); // see R15
			tv_detect_pin_oe_n_out <= detect_pin_tristate; // see R14
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Arrays; no reset, contents are undefined until written
	always_ff @(posedge core_clk_in) begin
		if (data_wr && ram_mode) begin
			if (subaddr == SUB_LINE_COUNT) begin
				line_ram[ram_ptr] <= rx_byte; // see R5
			end else if (subaddr == SUB_CURSOR) begin
				cursor_ram[ram_ptr] <= rx_byte; // see R6
			end else if (comp == 2'h0) begin
				clut_red[ram_ptr] <= rx_byte; // see R7
			end else if (comp == 2'h1) begin
				clut_green[ram_ptr] <= rx_byte;
			end else begin
				clut_blue[ram_ptr] <= rx_byte;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read data
	always_comb begin
		rd_byte = 8'h00;
		if (subaddr == SUB_DAC_FINE) begin
			rd_byte = {4'h0, dac_gain_fine_out};
		end else if (subaddr == SUB_RED_COARSE) begin
			rd_byte = {3'h0, red_level_coarse_out};
		end else if (subaddr == SUB_GREEN_COARSE) begin
			rd_byte = {3'h0, green_level_coarse_out};
		end else if (subaddr == SUB_BLUE_COARSE) begin
			rd_byte = {3'h0, blue_level_coarse_out};
		end else if (subaddr == SUB_THRESHOLD) begin
			rd_byte = sense_threshold_out;
		end else if (subaddr == SUB_SENSE) begin
			rd_byte = {monitor_sense_enable_out, auto_sense_enable_out, detect_pin_tristate,
				2'h0, load_status}; // see R15
		end else if (subaddr == SUB_WSS_LOW) begin
			rd_byte = wide_screen_bits_out[7:0];
		end else if (subaddr == SUB_WSS_HIGH) begin
			rd_byte = {wide_screen_output_enable_out, 1'b0, wide_screen_bits_out[13:8]};
		end else if (subaddr == SUB_BURST) begin
			rd_byte = burst_start_out;
		end else if (subaddr == SUB_LINE_COUNT) begin
			rd_byte = line_ram[ram_ptr];
		end else if (subaddr == SUB_CURSOR) begin
			rd_byte = cursor_ram[ram_ptr]; // see R8
		end else if (subaddr == SUB_CLUT) begin
			if (comp == 2'h0) begin
				rd_byte = clut_red[ram_ptr]; // see R8
			end else if (comp == 2'h1) begin
				rd_byte = clut_green[ram_ptr];
			end else begin
				rd_byte = clut_blue[ram_ptr];
			end
		end
	end
endmodule

// [rtl/i2c_host_master.sv]
// Host end of the control link: runs one register or array access per
// command and makes scl by dividing core_clk_in. Assumes the slave never
// stretches scl.
`timescale 1ns/10ps
module i2c_host_master import enc_i2c_pkg::*; (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	i2c_link_if.master link,
	input wire logic cmd_valid_in,
	input wire logic cmd_read_in,
	input wire logic cmd_ram_in,
	input wire logic [7:0] cmd_sub_in,
	input wire logic [7:0] cmd_ram_addr_in,
	input wire logic [7:0] cmd_len_in,
	input wire logic [7:0] wr_data_in,
	output logic busy_out,
	output logic wr_take_out,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic nack_out,
	output logic done_out
);
	typedef enum logic [1:0] {
		h_idle = 2'b00,
		h_start = 2'b01,
		h_bit = 2'b10,
		h_stop = 2'b11
	} host_state_type;

	typedef enum logic [2:0] {
		seg_addr_w = 3'b000,
		seg_sub = 3'b001,
		seg_ram = 3'b010,
		seg_data_w = 3'b011,
		seg_addr_r = 3'b100,
		seg_data_r = 3'b101
	} segment_type;

	host_state_type state;
	host_state_type next_state;
	segment_type seg;
	segment_type next_seg;
	logic [7:0] cnt;
	logic tick;
	logic [1:0] q;
	logic [3:0] bit_idx;
	logic [7:0] tx;
	logic [7:0] rx;
	logic [7:0] remaining;
	logic [7:0] sub;
	logic [7:0] ram_addr;
	logic rd_cmd;
	logic ram_cmd;
	logic ack_fail;
	logic [1:0] sda_sync;
	logic [7:0] next_tx;

	assign link.master_scl_out = 1'b0;
	assign link.master_sda_out = 1'b0;
	assign tick = (cnt == QUARTER_CNT);

	always_ff @(posedge core_clk_in) begin
		sda_sync <= {sda_sync[0], link.sda};
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in || tick) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Byte sequence of one access
	always_comb begin
		next_seg = seg;
		next_state = h_bit;
		case (seg)
			seg_addr_w: next_seg = seg_sub; // see R1
			seg_sub, seg_ram: begin
				if ((seg == seg_sub) && ram_cmd) begin
					next_seg = seg_ram; // see R5, R6, R7
				end else if (rd_cmd) begin
					next_seg = seg_addr_r; // see R2, R8
					next_state = h_start;
				end else if (remaining == 8'h00) begin
					next_state = h_stop;
				end else begin
					next_seg = seg_data_w;
				end
			end
			seg_addr_r: next_seg = seg_data_r;
			default: begin
				if (remaining == 8'h01) begin
					next_state = h_stop;
				end
			end
		endcase
		case (next_seg)
			seg_addr_w: next_tx = {DEV_ADDR, 1'b0}; // see R3
			seg_sub: next_tx = sub;
			seg_ram: next_tx = ram_addr;
			seg_data_w: next_tx = wr_data_in;
			seg_addr_r: next_tx = {DEV_ADDR, 1'b1};
			default: next_tx = 8'hff;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Bit engine: four quarter-periods per scl cycle
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			state <= h_idle;
			seg <= seg_addr_w;
			q <= 2'h0;
			bit_idx <= 4'h0;
			tx <= 8'hff;
			rx <= 8'h00;
			remaining <= 8'h00;
			sub <= 8'h00;
			ram_addr <= 8'h00;
			rd_cmd <= 1'b0;
			ram_cmd <= 1'b0;
			ack_fail <= 1'b0;
			busy_out <= 1'b0;
			wr_take_out <= 1'b0;
			rd_data_out <= 8'h00;
			rd_valid_out <= 1'b0;
			nack_out <= 1'b0;
			done_out <= 1'b0;
			link.master_scl_oe_n <= 1'b1;
			link.master_sda_oe_n <= 1'b1;
		end else begin
			wr_take_out <= 1'b0;
			rd_valid_out <= 1'b0;
			done_out <= 1'b0;
			if (state == h_idle) begin
				if (cmd_valid_in) begin
					state <= h_start;
					seg <= seg_addr_w;
					q <= 2'h0;
					sub <= cmd_sub_in;
					ram_addr <= cmd_ram_addr_in;
					rd_cmd <= cmd_read_in;
					ram_cmd <= cmd_ram_in;
					// A read always fetches at least one byte
					remaining <= (cmd_read_in && cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
					ack_fail <= 1'b0;
					nack_out <= 1'b0;
					busy_out <= 1'b1;
				end
			end else if (tick) begin
				q <= q + 2'h1;
				case (state)
					h_start: begin
						case (q)
							2'h0: begin
								link.master_scl_oe_n <= 1'b0;
								link.master_sda_oe_n <= 1'b1;
							end
							2'h1: link.master_scl_oe_n <= 1'b1;
							2'h2: link.master_sda_oe_n <= 1'b0;
							default: begin
								link.master_scl_oe_n <= 1'b0;
								tx <= (seg == seg_addr_r) ? {DEV_ADDR, 1'b1} : {DEV_ADDR, 1'b0};
								bit_idx <= 4'h0;
								state <= h_bit;
							end
						endcase
					end
					h_bit: begin
						case (q)
							2'h0: begin
								if (bit_idx == 4'h8) begin
									// Master acknowledges all but the last read byte
									link.master_sda_oe_n <= (seg == seg_data_r) ? (remaining == 8'h01) : 1'b1; // see R2
								end else begin
									link.master_sda_oe_n <= tx[7];
									tx <= {tx[6:0], 1'b1};
								end
							end
							2'h1: link.master_scl_oe_n <= 1'b1;
							2'h2: begin
								if (bit_idx != 4'h8) begin
									rx <= {rx[6:0], sda_sync[1]};
								end else if (seg != seg_data_r) begin
									ack_fail <= sda_sync[1]; // see R1
								end
							end
							default: begin
								link.master_scl_oe_n <= 1'b0;
								if (bit_idx != 4'h8) begin
									bit_idx <= bit_idx + 4'h1;
								end else begin
									bit_idx <= 4'h0;
									if (seg == seg_data_w || seg == seg_data_r) begin
										remaining <= remaining - 8'h01;
									end
									if (seg == seg_data_r) begin
										rd_data_out <= rx;
										rd_valid_out <= 1'b1;
									end
									if (ack_fail) begin
										nack_out <= 1'b1;
										state <= h_stop;
									end else begin
										state <= next_state;
										seg <= next_seg;
										tx <= next_tx;
										wr_take_out <= (next_state == h_bit) && (next_seg == seg_data_w);
									end
								end
							end
						endcase
					end
					default: begin
						case (q)
							2'h0: link.master_sda_oe_n <= 1'b0;
							2'h1: link.master_scl_oe_n <= 1'b1;
							2'h2: link.master_sda_oe_n <= 1'b1;
							default: begin
								state <= h_idle;
								busy_out <= 1'b0;
								done_out <= 1'b1;
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule

// [verif/i2c_link_checker.sv]
// Wire checks for the encoder control link.
// Assumes both ends run on core_clk_in; sees the interface signals only.
`timescale 1ns/10ps
module i2c_link_checker import enc_i2c_pkg::*; (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic slave_sda_oe_n,
	input wire logic master_scl_oe_n,
	input wire logic master_sda_oe_n
);
	logic [3:0] bits;
	logic [7:0] shf;
	logic first;
	logic rd;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////////////////////////////////////
	// Bits of the current byte, cleared at start and after each ack slot; the ack slot follows count 8
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in || (scl && $fell(sda))) begin
			bits <= 4'h0;
			first <= 1'b1;
		end else if ($rose(scl)) begin
			bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
			shf <= {shf[6:0], sda};
		end else if ($fell(scl) && bits == 4'h8 && first) begin
			first <= 1'b0;
			rd <= shf[0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_ack_scl_low: assert property ($fell(slave_sda_oe_n) |-> !scl) else $error("slave drove sda while scl high");
	a_release_scl_low: assert property ($rose(slave_sda_oe_n) |-> !scl) else $error("slave released sda in scl high");
	a_drive_stands: assert property ($fell(slave_sda_oe_n) |=> !slave_sda_oe_n [*8]) else $error("slave drive too short");
	// Sync flops delay every answer; an earlier change means a glitchy path
	a_answer_latency: assert property ($fell(scl) |=> $stable(slave_sda_oe_n) [*2]) else $error("slave answered too fast");
	a_reset_idle: assert property ($rose(reset_n_in) |->
		slave_sda_oe_n && master_sda_oe_n && master_scl_oe_n) else $error("link not released after reset");
	a_start_quiet: assert property (scl && $fell(sda) |=> slave_sda_oe_n [*8]) else $error("slave drove after start");
	a_addr_ack: assert property ($fell(scl) && bits == 4'h8 && first && shf[7:1] == DEV_ADDR |->
		##[2:8] !slave_sda_oe_n) else $error("own address not acked");
	a_write_ack: assert property ($fell(scl) && bits == 4'h8 && !first && !rd |->
		##[2:8] !slave_sda_oe_n) else $error("written byte not acked");
	c_addr: cover property ($fell(scl) && bits == 4'h8 && first);
	c_read_byte: cover property ($fell(scl) && bits == 4'h8 && !first && rd);
	c_stop: cover property (scl && $rose(sda));
endmodule

// [verif/i2c_control_register_port_tb.sv]
// Testbench: host master and encoder port joined by the link.
// Assumes scl at 400 kHz, so a byte costs 900 cycles; keep transfers few.
`timescale 1ns/10ps
module i2c_control_register_port_tb import enc_i2c_pkg::*;;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic strap = 1'b1;
	logic [2:0] load_status = 3'b010;
	logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_ram = 1'b0;
	logic [7:0] cmd_sub = 8'h00, cmd_ram_addr = 8'h00, cmd_len = 8'h00, wr_data = 8'h00;
	logic busy, wr_take, rd_valid, nack, done, sense_en, auto_en, auto_act, tv_detect_pin, tvd_oe_n, wss_en;
	logic [7:0] rd_data, thr, burst;
	logic [4:0] red, green, blue;
	logic [3:0] fine;
	logic [13:0] wide_screen_bits_low;
	logic [7:0] wq[$], rq[$];
	int errors = 0, checks_done = 0;
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	i2c_link_if i2c_link_if_i ();
	i2c_host_master i2c_host_master_i (.core_clk_in(clk), .reset_n_in(reset_n), .link(i2c_link_if_i.master),
		.cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read), .cmd_ram_in(cmd_ram), .cmd_sub_in(cmd_sub),
		.cmd_ram_addr_in(cmd_ram_addr), .cmd_len_in(cmd_len), .wr_data_in(wr_data), .busy_out(busy),
		.wr_take_out(wr_take), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .nack_out(nack), .done_out(done));
	video_encoder_i2c_port video_encoder_i2c_port_i (.core_clk_in(clk), .reset_n_in(reset_n),
		.link(i2c_link_if_i.slave), .standard_strap_pin_in(strap), .red_load_status_in(load_status[2]),
		.green_load_status_in(load_status[1]), .blue_load_status_in(load_status[0]), .dac_gain_fine_out(fine),
		.red_level_coarse_out(red), .green_level_coarse_out(green), .blue_level_coarse_out(blue),
		.sense_threshold_out(thr), .monitor_sense_enable_out(sense_en), .auto_sense_enable_out(auto_en),
		.auto_sense_active_out(auto_act), .tv_detect_pin_out(tv_detect_pin), .tv_detect_pin_oe_n_out(tvd_oe_n),
		.wide_screen_bits_out(wide_screen_bits_low), .wide_screen_output_enable_out(wss_en), .burst_start_out(burst));
	i2c_link_checker i2c_link_checker_i (.core_clk_in(clk), .reset_n_in(reset_n), .scl(i2c_link_if_i.scl),
		.sda(i2c_link_if_i.sda), .slave_sda_oe_n(i2c_link_if_i.slave_sda_oe_n),
		.master_scl_oe_n(i2c_link_if_i.master_scl_oe_n), .master_sda_oe_n(i2c_link_if_i.master_sda_oe_n));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One access; next write byte goes out only after the host took the last
	task automatic run(input logic rd, input logic [7:0] sub, input logic [7:0] ra, input logic [7:0] len);
		int i = 0;
		@(posedge clk);
		#1;
		cmd_read = rd;
		cmd_ram = sub inside {SUB_LINE_COUNT, SUB_CURSOR, SUB_CLUT};
		cmd_sub = sub;
		cmd_ram_addr = ra;
		cmd_len = len;
		wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
		cmd_valid = 1'b1;
		rq = {};
		for (int n = 0; n < 10000 && done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (busy === 1'b1) cmd_valid = 1'b0;
			if (wr_take === 1'b1) begin
				i++;
				if (i < wq.size()) wr_data = wq[i];
			end
			if (rd_valid === 1'b1) rq.push_back(rd_data);
		end
		check(16'(done), 16'h1);
		check(16'(nack), 16'h0);
		wq = {};
	endtask
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		check(16'({red, green, blue}), 16'({5'h1b, 5'h1b, 5'h1f}));
		check(16'({tvd_oe_n, wss_en, fine}), 16'h20);
		check(16'(burst), 16'h21);
		$display("test reset_values done");
		// Status bits written as ones must not stick
		wq = {8'h0f, 8'h05, 8'h06, 8'h1e, 8'h46, 8'h47};
		run(1'b0, SUB_DAC_FINE, 8'h00, 8'h06);
		check(16'(fine), 16'h0f);
		check(16'({red, green, blue}), 16'({5'h05, 5'h06, 5'h1e}));
		check(16'(thr), 16'h46);
		check(16'({sense_en, auto_en, auto_act}), 16'h3);
		check(16'({tvd_oe_n, tv_detect_pin}), 16'h1);
		$display("test register_write done");
		run(1'b1, SUB_SENSE, 8'h00, 8'h02);
		check(16'(rq[0]), 16'h42);
		check(16'(rq[1]), 16'h00);
		$display("test register_read done");
		wq = {8'ha5, 8'hab};
		run(1'b0, SUB_WSS_LOW, 8'h00, 8'h02);
		check(16'(wide_screen_bits_low), 16'h2ba5);
		check(16'(wss_en), 16'h1);
		$display("test wide_screen done");
		wq = {8'h11, 8'h22, 8'h33};
		run(1'b0, SUB_CLUT, 8'h10, 8'h03);
		run(1'b1, SUB_CLUT, 8'h10, 8'h03);
		check(16'(rq.size()), 16'h3);
		for (int k = 0; k < 3; k++) check(16'(rq[k]), 16'(8'h11 * (k + 1)));
		$display("test colour_table done");
		wq = {8'h5a, 8'h3c};
		run(1'b0, SUB_CURSOR, 8'h20, 8'h02);
		run(1'b1, SUB_CURSOR, 8'h20, 8'h02);
		check(16'({rq[0], rq[1]}), 16'h5a3c);
		$display("test cursor_map done");
		// Second reset with the strap low picks the other burst default
		strap = 1'b0;
		reset_n = 1'b0;
		repeat (10) @(posedge clk);
		#1 reset_n = 1'b1;
		check(16'({tvd_oe_n, wss_en, burst}), 16'h219);
		run(1'b1, SUB_SENSE, 8'h00, 8'h01);
		check(16'(rq[0]), 16'h27);
		$display("test second_reset done");
		report_and_stop();
	end
endmodule
